// ### rtl/sdc_ctrl.sv
// Purpose: command spacing and low-power policy for an sdram controller
// Assumes: aclk 100 MHz, link_clk asynchronous and sampled here
// Notes:   delay counters count memory clock rising edges
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - wait mode-load delay before activate or refresh
// - wait refresh delay before activate or refresh
// - self-refresh exit delay before non-read commands
// - ddr self-refresh exit delay before reads
// - power-down exit delay before any command
// - fast active power-down exit read delay
// - slow active power-down exit read delay
// - precharge-all delay before any command
// - read to precharge minimum spacing
// - write protect blocks configuration writes
// - low-power command 00 issues nothing
// - 01 self refresh, clock stopped, cke low
// - 10 power-down after every access
// - 11 deep power-down, low-power sdr only
// - clock freeze holds memory clock low
// - partial array field sent to memory
// - partial array change rewrites extended mode
// - update policy: off, at refresh, before self-refresh
// - idle timeout immediate, 64 or 128 cycles; setting 11 never enters low power
// - exit speed bit picks read delay
module sdc_ctrl (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [sdc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [sdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  init_done,
  input  wire logic                  cmd_valid,
  input  wire sdc_pkg::sdc_cmd_t     cmd_code,
  output logic                       cmd_ready,
  input  wire logic                  link_clk,
  output sdc_pkg::sdc_cmd_t          mem_cmd_reg,
  output logic                       mem_cke_reg,
  output logic                       mem_clk_en_reg,
  output logic [11:0]                emr_data_reg
);
  import sdc_pkg::*;

  logic [31:0] t0_reg, t1_reg, t2_reg, lpc_reg, cfg_reg;
  logic        wp_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_held_reg, w_held_reg;
  logic        lk_s1_reg, lk_s2_reg, lk_s3_reg;
  logic        link_rise;
  sdc_state_t  state_reg;
  logic        lp_sr_reg, emr_pend_reg, emr_then_sr_reg;
  logic [7:0]  idle_reg;
  logic [3:0]  lmr_cnt_reg, xp_cnt_reg, xard_cnt_reg, rpa_cnt_reg, rtp_cnt_reg;
  logic [4:0]  rfc_cnt_reg;
  logic [7:0]  xsnr_cnt_reg, xsrd_cnt_reg;
  logic        is_ddr, is_ddr2, take, wr_fire, lp_enter, lp_exit, idle_done;
  logic [1:0]  lp_mode;
  logic [11:0] emr_bits, emr_bits_new;
  logic [31:0] lpc_new;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r & msk;
  endfunction

  function automatic logic [7:0] dec8(input logic [7:0] v, input logic tick);
    return (tick && v != 8'h00) ? v - 8'h01 : v;
  endfunction

  function automatic logic [3:0] dec4(input logic [3:0] v, input logic tick);
    return (tick && v != 4'h0) ? v - 4'h1 : v;
  endfunction

  function automatic logic [7:0] idle_limit(input logic [1:0] sel);
    unique case (sel)
      2'b00:   return 8'h00;
      2'b01:   return IDLE_64;
      default: return IDLE_128;
    endcase
  endfunction

  // register views
  logic [3:0] mode_load_to_activate_delay, powerdown_exit_delay;
  logic [4:0] refresh_cycle_delay;
  logic [7:0] self_refresh_exit_nonread_delay, self_refresh_exit_read_delay;
  logic [3:0] fast_active_pd_exit_read_delay, slow_active_pd_exit_read_delay;
  logic [3:0] precharge_all_delay, read_to_precharge_delay;
  logic [1:0] low_power_command, mode_reg_update_policy, lp_timeout;
  logic       clock_freeze, active_pd_exit_speed;
  assign mode_load_to_activate_delay     = t0_reg[T0_MRD +: 4];
  assign refresh_cycle_delay             = t1_reg[T1_RFC +: 5];
  assign self_refresh_exit_nonread_delay = t1_reg[T1_XSNR +: 8];
  assign self_refresh_exit_read_delay    = t1_reg[T1_XSRD +: 8];
  assign powerdown_exit_delay            = t1_reg[T1_XP +: 4];
  assign fast_active_pd_exit_read_delay  = t2_reg[T2_XARD +: 4];
  assign slow_active_pd_exit_read_delay  = t2_reg[T2_XARDS +: 4];
  assign precharge_all_delay             = t2_reg[T2_RPA +: 4];
  assign read_to_precharge_delay         = t2_reg[T2_RTP +: 4];
  assign low_power_command               = lpc_reg[LP_CMD +: 2];
  assign clock_freeze                    = lpc_reg[LP_CLKFR];
  assign lp_timeout                      = lpc_reg[LP_TMO +: 2];
  assign active_pd_exit_speed            = lpc_reg[LP_ACTIVE_PD_EXIT_SPEED];
  assign mode_reg_update_policy          = lpc_reg[LP_UPD +: 2];
  // partial_array_refresh, tcr, ds and exit speed bits as written to the extended mode register
  assign emr_bits = {lpc_reg[LP_ACTIVE_PD_EXIT_SPEED], lpc_reg[LP_DS +: 2], lpc_reg[LP_TCR +: 2],
                     4'h0, lpc_reg[LP_PARTIAL_ARRAY_REFRESH +: 3]};
  assign lpc_new  = merge(lpc_reg, wdata_reg, wstrb_reg, MSK_LPC);
  assign emr_bits_new = {lpc_new[LP_ACTIVE_PD_EXIT_SPEED], lpc_new[LP_DS +: 2], lpc_new[LP_TCR +: 2],
                         4'h0, lpc_new[LP_PARTIAL_ARRAY_REFRESH +: 3]};
  assign is_ddr2  = (cfg_reg[2:0] == MT_DDR2);
  assign is_ddr   = is_ddr2 || (cfg_reg[2:0] == MT_LPDDR);

  // deep power-down only on low-power sdr, otherwise inhibited
  assign lp_mode = (low_power_command == 2'b11 && cfg_reg[2:0] != MT_LPSDR)
                   ? 2'b00 : low_power_command;

  // axi write channel
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg[1:0] != 2'b00 || awaddr_reg > OFS_STAT)
                        ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers, silently held while protected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t0_reg  <= RST_T0;
      t1_reg  <= RST_T1;
      t2_reg  <= RST_T2;
      lpc_reg <= RST_LPC;
      cfg_reg <= RST_CFG;
      wp_reg  <= 1'b0;
    end else if (wr_fire) begin
      if (awaddr_reg == OFS_WP && wstrb_reg[0]) begin
        wp_reg <= wdata_reg[0];
      end
      if (!wp_reg) begin
        unique case (awaddr_reg)
          OFS_T0:  t0_reg  <= merge(t0_reg, wdata_reg, wstrb_reg, MSK_T0);
          OFS_T1:  t1_reg  <= merge(t1_reg, wdata_reg, wstrb_reg, MSK_T1);
          OFS_T2:  t2_reg  <= merge(t2_reg, wdata_reg, wstrb_reg, MSK_T2);
          OFS_LPC: lpc_reg <= merge(lpc_reg, wdata_reg, wstrb_reg, MSK_LPC);
          OFS_CFG: cfg_reg <= merge(cfg_reg, wdata_reg, wstrb_reg, MSK_CFG);
          default: ;
        endcase
      end
    end
  end

  // axi read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_T0:   s_axi_rdata <= t0_reg;
        OFS_T1:   s_axi_rdata <= t1_reg;
        OFS_T2:   s_axi_rdata <= t2_reg;
        OFS_LPC:  s_axi_rdata <= lpc_reg;
        OFS_CFG:  s_axi_rdata <= cfg_reg;
        OFS_WP:   s_axi_rdata <= {31'h0000_0000, wp_reg};
        OFS_STAT: s_axi_rdata <= {23'h00_0000, emr_pend_reg, lp_sr_reg,
                                  mem_cke_reg, mem_clk_en_reg, 1'b0, state_reg, !cmd_ready};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // link clock synchroniser and edge finder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lk_s1_reg <= 1'b0;
      lk_s2_reg <= 1'b0;
      lk_s3_reg <= 1'b0;
    end else begin
      lk_s1_reg <= link_clk;
      lk_s2_reg <= lk_s1_reg;
      lk_s3_reg <= lk_s2_reg;
    end
  end
  assign link_rise = lk_s2_reg && !lk_s3_reg;

  // command admission
  always_comb begin
    cmd_ready = 1'b0;
    if (state_reg == ST_ACTIVE && link_rise && !lp_enter && xp_cnt_reg == 4'h0
        && rpa_cnt_reg == 4'h0) begin
      unique case (cmd_code)
        CMD_ACT, CMD_REF:
          cmd_ready = lmr_cnt_reg == 4'h0 && rfc_cnt_reg == 5'h00
                      && xsnr_cnt_reg == 8'h00;
        CMD_RD:
          cmd_ready = xsrd_cnt_reg == 8'h00 && xard_cnt_reg == 4'h0;
        CMD_PRE, CMD_PREALL:
          cmd_ready = rtp_cnt_reg == 4'h0 && xsnr_cnt_reg == 8'h00;
        CMD_WR, CMD_LMR, CMD_NOP:
          cmd_ready = xsnr_cnt_reg == 8'h00;
        default:
          cmd_ready = 1'b0;
      endcase
    end
  end
  assign take = cmd_valid && cmd_ready;

  // idle counting and low-power transitions
  assign idle_done = idle_reg >= idle_limit(lp_timeout) && lp_timeout != 2'b11;
  assign lp_enter  = state_reg == ST_ACTIVE && link_rise && !cmd_valid && init_done
                     && lp_mode != 2'b00 && idle_done && xsnr_cnt_reg == 8'h00
                     && xp_cnt_reg == 4'h0 && rpa_cnt_reg == 4'h0;
  // a stopped memory clock gives no edges, so wake without one
  assign lp_exit   = state_reg == ST_LOW && (link_rise || !mem_clk_en_reg) && cmd_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_reg <= 8'h00;
    end else if (state_reg != ST_ACTIVE || cmd_valid) begin
      idle_reg <= 8'h00;
    end else if (link_rise && idle_reg != 8'hFF) begin
      idle_reg <= idle_reg + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg       <= ST_ACTIVE;
      lp_sr_reg       <= 1'b0;
      emr_then_sr_reg <= 1'b0;
      mem_cmd_reg     <= CMD_NOP;
      mem_cke_reg     <= 1'b1;
      mem_clk_en_reg  <= 1'b1;
      emr_data_reg    <= 12'h000;
    end else begin
      mem_cmd_reg <= take ? cmd_code : CMD_NOP;
      unique case (state_reg)
        ST_ACTIVE: begin
          if (take && cmd_code == CMD_REF && emr_pend_reg
              && mode_reg_update_policy == 2'b01) begin
            state_reg <= ST_EMR;
          end else if (lp_enter && lp_mode == 2'b01 && emr_pend_reg
                       && mode_reg_update_policy == 2'b10) begin
            state_reg       <= ST_EMR;
            emr_then_sr_reg <= 1'b1;
          end else if (lp_enter) begin
            state_reg   <= ST_LOW;
            lp_sr_reg   <= lp_mode == 2'b01;
            mem_cke_reg <= 1'b0;
            unique case (lp_mode)
              2'b01:   mem_cmd_reg <= CMD_SREF;
              2'b10:   mem_cmd_reg <= CMD_PDN;
              default: mem_cmd_reg <= CMD_DPD;
            endcase
            mem_clk_en_reg <= lp_mode != 2'b01 && !clock_freeze;
          end
        end
        ST_EMR: begin
          if (link_rise) begin
            mem_cmd_reg     <= CMD_EMR;
            emr_data_reg    <= emr_bits;
            emr_then_sr_reg <= 1'b0;
            state_reg       <= ST_ACTIVE;
          end
        end
        ST_LOW: begin
          if (lp_exit) begin
            state_reg      <= ST_ACTIVE;
            mem_cke_reg    <= 1'b1;
            mem_clk_en_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // pending extended mode rewrite, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emr_pend_reg <= 1'b0;
    end else if (wr_fire && !wp_reg && awaddr_reg == OFS_LPC && init_done
                 && lpc_new != lpc_reg && emr_bits != emr_bits_new) begin
      emr_pend_reg <= 1'b1;
    end else if (state_reg == ST_EMR && link_rise) begin
      emr_pend_reg <= 1'b0;
    end
  end

  // spacing counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lmr_cnt_reg  <= 4'h0;
      rfc_cnt_reg  <= 5'h00;
      xsnr_cnt_reg <= 8'h00;
      xsrd_cnt_reg <= 8'h00;
      xp_cnt_reg   <= 4'h0;
      xard_cnt_reg <= 4'h0;
      rpa_cnt_reg  <= 4'h0;
      rtp_cnt_reg  <= 4'h0;
    end else begin
      lmr_cnt_reg  <= dec4(lmr_cnt_reg, link_rise);
      rfc_cnt_reg  <= (link_rise && rfc_cnt_reg != 5'h00) ? rfc_cnt_reg - 5'h01 : rfc_cnt_reg;
      xsnr_cnt_reg <= dec8(xsnr_cnt_reg, link_rise);
      xsrd_cnt_reg <= dec8(xsrd_cnt_reg, link_rise);
      xp_cnt_reg   <= dec4(xp_cnt_reg, link_rise);
      xard_cnt_reg <= dec4(xard_cnt_reg, link_rise);
      rpa_cnt_reg  <= dec4(rpa_cnt_reg, link_rise);
      rtp_cnt_reg  <= dec4(rtp_cnt_reg, link_rise);
      if ((take && cmd_code == CMD_LMR) || (state_reg == ST_EMR && link_rise)) begin
        lmr_cnt_reg <= mode_load_to_activate_delay;
      end
      if (take && cmd_code == CMD_REF) begin
        rfc_cnt_reg <= refresh_cycle_delay;
      end
      if (take && cmd_code == CMD_RD) begin
        rtp_cnt_reg <= read_to_precharge_delay;
      end
      if (take && cmd_code == CMD_PREALL && is_ddr2) begin
        rpa_cnt_reg <= precharge_all_delay;
      end
      if (lp_exit && lp_sr_reg) begin
        xsnr_cnt_reg <= self_refresh_exit_nonread_delay;
        xsrd_cnt_reg <= is_ddr ? self_refresh_exit_read_delay
                               : self_refresh_exit_nonread_delay;
      end
      if (lp_exit && !lp_sr_reg && is_ddr) begin
        xp_cnt_reg <= powerdown_exit_delay;
      end
      if (lp_exit && !lp_sr_reg && is_ddr2) begin
        xard_cnt_reg <= active_pd_exit_speed ? slow_active_pd_exit_read_delay
                                             : fast_active_pd_exit_read_delay;
      end
    end
  end

  lmr_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && cmd_code == CMD_LMR) |=> lmr_cnt_reg == $past(mode_load_to_activate_delay))
    else $error("mode load delay not loaded");
  rfc_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && (cmd_code == CMD_ACT || cmd_code == CMD_REF)) |-> rfc_cnt_reg == 5'h00)
    else $error("activate or refresh inside refresh delay");
  xsnr_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lp_exit && lp_sr_reg) |=> xsnr_cnt_reg == $past(self_refresh_exit_nonread_delay))
    else $error("self refresh exit delay not loaded");
  xsrd_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && cmd_code == CMD_RD) |-> xsrd_cnt_reg == 8'h00 && xard_cnt_reg == 4'h0)
    else $error("read inside exit read delay");
  xp_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    take |-> xp_cnt_reg == 4'h0 && rpa_cnt_reg == 4'h0)
    else $error("command inside power-down exit or precharge-all delay");
  apd_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lp_exit && !lp_sr_reg && is_ddr2) |=> xard_cnt_reg == ($past(active_pd_exit_speed)
      ? $past(slow_active_pd_exit_read_delay) : $past(fast_active_pd_exit_read_delay)))
    else $error("wrong active power-down exit read delay");
  rtp_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && cmd_code == CMD_RD) |=> rtp_cnt_reg == $past(read_to_precharge_delay))
    else $error("read to precharge delay not loaded");
  wp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wp_reg) |=> $stable(t1_reg) && $stable(t2_reg) && $stable(lpc_reg))
    else $error("protected register changed");
  lp_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (low_power_command == 2'b00 && state_reg == ST_ACTIVE) |=> state_reg != ST_LOW)
    else $error("low-power entry while inhibited");
  cke_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_LOW |-> !mem_cke_reg && (!lp_sr_reg || !mem_clk_en_reg))
    else $error("cke or clock active in low power");
endmodule
`default_nettype wire

// ### shared/sdc_pkg.sv
// Purpose: constants and types for the sdram timing and low-power control block
// Assumes: AXI4-Lite register access, 32-bit words
// Notes:   offsets are byte addresses
package sdc_pkg;
  localparam int          ADDR_W      = 5;
  localparam logic [4:0]  OFS_T0      = 5'h00;
  localparam logic [4:0]  OFS_T1      = 5'h04;
  localparam logic [4:0]  OFS_T2      = 5'h08;
  localparam logic [4:0]  OFS_LPC     = 5'h0C;
  localparam logic [4:0]  OFS_CFG     = 5'h10;
  localparam logic [4:0]  OFS_WP      = 5'h14;
  localparam logic [4:0]  OFS_STAT    = 5'h18;
  localparam logic [31:0] RST_T0      = 32'h2000_0000;
  localparam logic [31:0] RST_T1      = 32'h03C8_0808;
  localparam logic [31:0] RST_T2      = 32'h0000_2000;
  localparam logic [31:0] RST_LPC     = 32'h0001_0000;
  localparam logic [31:0] RST_CFG     = 32'h0000_0000;
  localparam logic [31:0] MSK_T0      = 32'hF000_0000;
  localparam logic [31:0] MSK_T1      = 32'h0FFF_FF1F;
  localparam logic [31:0] MSK_T2      = 32'h0000_FFFF;
  localparam logic [31:0] MSK_LPC     = 32'h0031_3F77;
  localparam logic [31:0] MSK_CFG     = 32'h0000_0007;
  // field positions
  localparam int          T0_MRD      = 28;
  localparam int          T1_RFC      = 0;
  localparam int          T1_XSNR     = 8;
  localparam int          T1_XSRD     = 16;
  localparam int          T1_XP       = 24;
  localparam int          T2_XARD     = 0;
  localparam int          T2_XARDS    = 4;
  localparam int          T2_RPA      = 8;
  localparam int          T2_RTP      = 12;
  localparam int          LP_CMD      = 0;
  localparam int          LP_CLKFR    = 2;
  localparam int          LP_PARTIAL_ARRAY_REFRESH     = 4;
  localparam int          LP_TCR      = 8;
  localparam int          LP_DS       = 10;
  localparam int          LP_TMO      = 12;
  localparam int          LP_ACTIVE_PD_EXIT_SPEED     = 16;
  localparam int          LP_UPD      = 20;
  localparam logic [7:0]  IDLE_64     = 8'h40;
  localparam logic [7:0]  IDLE_128    = 8'h80;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [2:0]  MT_SDR      = 3'b000;
  localparam logic [2:0]  MT_LPSDR    = 3'b001;
  localparam logic [2:0]  MT_LPDDR    = 3'b011;
  localparam logic [2:0]  MT_DDR2     = 3'b110;

  typedef enum logic [3:0] {
    CMD_NOP    = 4'h0,
    CMD_ACT    = 4'h1,
    CMD_RD     = 4'h2,
    CMD_WR     = 4'h3,
    CMD_PRE    = 4'h4,
    CMD_PREALL = 4'h5,
    CMD_REF    = 4'h6,
    CMD_LMR    = 4'h7,
    CMD_EMR    = 4'h8,
    CMD_SREF   = 4'h9,
    CMD_PDN    = 4'hA,
    CMD_DPD    = 4'hB
  } sdc_cmd_t;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_EMR    = 3'b010,
    ST_LOW    = 3'b100
  } sdc_state_t;
endpackage

// ### verif/sdc_mem_model.sv
// Purpose: memory side of the sdram control bench, source of the memory clock
// Assumes: 80 ns memory clock, phase unrelated to aclk
// Notes:   clock parks low while the controller freezes it
`timescale 1ns/100ps
`default_nettype none
module sdc_mem_model (
  input  wire logic clk_en,
  output logic      link_clk
);
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever begin
      #40;
      link_clk = clk_en ? ~link_clk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Purpose: self-checking bench for sdc_ctrl
// Assumes: memory clock from sdc_mem_model
// Notes:   random register data from an xorshift seeded at 49806
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sdc_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, init_done = 1'b0, cmd_valid = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, r, rnd, seed = 32'd49806;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid, cmd_ready, link_clk, cke, clk_en, ckq;
  logic [2:0]  ls = 3'h0;
  sdc_cmd_t    cmd_code = CMD_NOP, mem_cmd;
  int          err_count = 0, checked = 0, cyc = 0, gap = 0, last_gap = 0, i;
  logic [31:0] rst [4] = '{32'h2000_0000, 32'h03C8_0808, 32'h0000_2000, 32'h0001_0000};
  logic [4:0]  ad [3] = '{OFS_T0, OFS_T1, OFS_T2};
  logic [31:0] mk [3] = '{MSK_T0, MSK_T1, MSK_T2};
  sdc_cmd_t    pa [4] = '{CMD_LMR, CMD_REF, CMD_RD, CMD_PREALL};
  sdc_cmd_t    pb [4] = '{CMD_ACT, CMD_REF, CMD_PRE, CMD_ACT};
  int          pn [4] = '{3, 5, 4, 6};

  sdc_ctrl dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .init_done(init_done), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_ready(cmd_ready), .link_clk(link_clk), .mem_cmd_reg(mem_cmd),
    .mem_cke_reg(cke), .mem_clk_en_reg(clk_en), .emr_data_reg());
  sdc_mem_model mem_u (.clk_en(clk_en), .link_clk(link_clk));

  always #5 aclk = ~aclk;

  // memory clock rises between commands, restarted at every command or cke rise
  always @(posedge aclk) begin
    ls  <= {ls[1:0], link_clk};
    ckq <= cke;
    cyc <= cyc + 1;
    if (mem_cmd != CMD_NOP || (cke && !ckq)) begin
      last_gap <= gap;
      gap      <= 0;
    end else if (ls[1] && !ls[2])
      gap <= gap + 1;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [4:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    r = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic issue(input sdc_cmd_t c);
    @(posedge aclk);
    cmd_code  <= c;
    cmd_valid <= 1'b1;
    do @(posedge aclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge aclk);
    chk("mem_cmd", 32'(mem_cmd), 32'(c));
    @(posedge aclk);
  endtask

  task automatic wait_low();
    for (int k = 0; k < 3000 && (cke | clk_en) !== 1'b0 && cke !== 1'b0; k++)
      @(posedge aclk);
  endtask

  task test_done();
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn   <= 1'b1;
    init_done <= 1'b1;
    for (i = 0; i < 4; i++) begin
      axr(5'(4 * i));
      chk("reset value", r, rst[i]);
    end
    axw(OFS_T2, 32'hFFFF_FFFF, 4'h1);
    axr(OFS_T2);
    chk("byte strobe", r, 32'h0000_20FF);
    for (i = 0; i < 6; i++) begin
      rnd = xs();
      axw(ad[i % 3], rnd, 4'hF);
      axr(ad[i % 3]);
      chk("random rw", r, rnd & mk[i % 3]);
    end
    axw(OFS_T0, 32'h3000_0000, 4'hF);
    axw(OFS_T1, 32'h0207_0605, 4'hF);
    axw(OFS_T2, 32'h0000_4600, 4'hF);
    axw(OFS_CFG, 32'h6, 4'hF);
    axw(OFS_WP, 32'h1, 4'hF);
    axw(OFS_T1, 32'h0, 4'hF);
    axr(OFS_T1);
    chk("protected", r, 32'h0207_0605);
    axw(OFS_WP, 32'h0, 4'hF);
    axr(5'h1C);
    chk("unmapped", 32'(resp), 32'(RESP_SLVERR));
    for (i = 0; i < 4; i++) begin
      issue(pa[i]);
      issue(pb[i]);
      chk("spacing", 32'(last_gap >= pn[i]), 32'h1);
    end
    repeat (300) @(posedge aclk);
    chk("cke idle", 32'(cke), 32'h1);
    axw(OFS_LPC, 32'h1, 4'hF);
    wait_low();
    chk("self refresh cke", 32'(cke), 32'h0);
    issue(CMD_ACT);
    chk("exit wait", 32'(last_gap >= 6), 32'h1);
    axw(OFS_LPC, 32'h6, 4'hF);
    issue(CMD_ACT);
    wait_low();
    repeat (40) @(posedge aclk);
    chk("power-down cke", 32'(cke), 32'h0);
    chk("clock frozen", 32'(clk_en), 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
